// ===== src/aimc_pkg.sv
// Package: register map, field layout, mode codes and timing of the input mode loader
package aimc_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int ADDR_W    = 4;
	localparam int DATA_W    = 8;
	localparam int REG_COUNT = 6;
	localparam logic [ADDR_W-1:0] OFS_INPUT_MUX = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_BIAS      = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_REF_MUX   = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_RATE_GAIN = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_EXC_MAG   = 4'hA;
	localparam logic [ADDR_W-1:0] OFS_EXC_ROUTE = 4'hB;
	localparam logic [2:0] IDX_NONE = 3'h7;
	localparam logic [DATA_W-1:0] RESET_VAL [REG_COUNT] =
		'{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};

	// ****************************************
	// Field layout and command byte
	// ****************************************
	localparam int MUX_POS_LO = 3;
	localparam int MUX_NEG_LO = 0;
	localparam int REF_SEL_LO = 3;
	localparam int GAIN_LO    = 4;
	localparam int RATE_LO    = 0;
	localparam int MAG_LO     = 0;
	localparam int ROUTE1_LO  = 4;
	localparam int ROUTE2_LO  = 0;
	localparam int CMD_READ_BIT = 7;
	localparam logic [4:0] BIT_CMD_LAST  = 5'h07;
	localparam logic [4:0] BIT_DATA_LAST = 5'h0F;
	localparam logic [4:0] BIT_READ_LOAD = 5'h10;
	localparam logic [4:0] BIT_MAX       = 5'h1F;

	// ****************************************
	// Documented mode codes
	// ****************************************
	localparam logic [7:0] CODE_MUX_INDUSTRIAL = 8'h08;
	localparam logic [7:0] CODE_MUX_THERMOCPL  = 8'h1A;
	localparam logic [7:0] CODE_MUX_THERMISTOR = 8'h3E;
	localparam logic [7:0] CODE_MUX_RTD        = 8'h25;
	localparam logic [7:0] CODE_BIAS_THERMOCPL = 8'h04;
	localparam logic [7:0] CODE_REF_PAIR0      = 8'h00;
	localparam logic [7:0] CODE_REF_PAIR1      = 8'h28;
	localparam logic [7:0] CODE_RG_40SPS_G1    = 8'h03;
	localparam logic [7:0] CODE_RG_40SPS_G2    = 8'h13;
	localparam logic [7:0] CODE_RG_5SPS_G32    = 8'h50;
	localparam logic [7:0] CODE_RG_5SPS_G64    = 8'h60;
	localparam logic [7:0] CODE_RG_20SPS_G1    = 8'h02;
	localparam logic [7:0] CODE_RG_20SPS_G4    = 8'h22;
	localparam logic [7:0] CODE_EXC_1MA        = 8'h06;
	localparam logic [7:0] CODE_ROUTE_THERMIST = 8'h76;
	localparam logic [7:0] CODE_ROUTE_RTD      = 8'h89;
	localparam logic [3:0] RATE_CODE_5SPS  = 4'h0;
	localparam logic [3:0] RATE_CODE_10SPS = 4'h1;
	localparam logic [3:0] RATE_CODE_20SPS = 4'h2;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_FREQ_MHZ   = 125;
	localparam int CONV_5SPS_US   = 200000;
	localparam int CONV_10SPS_US  = 100000;
	localparam int CONV_20SPS_US  = 50000;
	localparam int CONV_40SPS_US  = 25000;
	localparam int CONV_5SPS_CYC  = CONV_5SPS_US * CLK_FREQ_MHZ;
	localparam int CONV_10SPS_CYC = CONV_10SPS_US * CLK_FREQ_MHZ;
	localparam int CONV_20SPS_CYC = CONV_20SPS_US * CLK_FREQ_MHZ;
	localparam int CONV_40SPS_CYC = CONV_40SPS_US * CLK_FREQ_MHZ;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} aimc_spi_word_t;

	typedef struct packed {
		logic [7:0] inputMux;
		logic [7:0] bias;
		logic [7:0] refMux;
		logic [7:0] rateGain;
		logic [7:0] excMag;
		logic [7:0] excRoute;
	} aimc_regs_t;

	typedef enum logic [2:0] {
		MODE_NONE       = 3'b000,
		MODE_INDUSTRIAL = 3'b001,
		MODE_THERMOCPL  = 3'b011,
		MODE_THERMISTOR = 3'b010,
		MODE_RTD        = 3'b110
	} aimc_mode_t;

	typedef struct packed {
		logic [2:0] muxPos;
		logic [2:0] muxNeg;
		logic [7:0] biasMask;
		logic [1:0] refSel;
		logic [2:0] gainCode;
		logic [3:0] rateCode;
		logic [2:0] excMag;
		logic [3:0] excRoute1;
		logic [3:0] excRoute2;
	} aimc_analog_cfg_t;

	typedef enum logic [1:0] {
		CONV_IDLE = 2'b00,
		CONV_RUN  = 2'b01
	} aimc_conv_t;

	// Map a register offset to its slot; IDX_NONE when unmapped
	function automatic logic [2:0] regIndex(input logic [ADDR_W-1:0] a);
		if (a == OFS_INPUT_MUX) regIndex = 3'h0;
		else if (a == OFS_BIAS) regIndex = 3'h1;
		else if (a == OFS_REF_MUX) regIndex = 3'h2;
		else if (a == OFS_RATE_GAIN) regIndex = 3'h3;
		else if (a == OFS_EXC_MAG) regIndex = 3'h4;
		else if (a == OFS_EXC_ROUTE) regIndex = 3'h5;
		else regIndex = IDX_NONE;
	endfunction : regIndex

endpackage : aimc_pkg

// ===== src/aimc_reg_bank.sv
// Configuration register bank with registered read port
module aimc_reg_bank
	import aimc_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst_b,
	input  wire logic              wrEn,
	input  wire aimc_spi_word_t    wrWord,
	input  wire logic              rdEn,
	input  wire logic [ADDR_W-1:0] rdAddr,
	output logic      [DATA_W-1:0] rdData_r,
	output aimc_regs_t             regs
);

	logic [DATA_W-1:0] regArr_r [REG_COUNT];
	wire  [2:0]        wrIdx = regIndex(wrWord.addr);
	wire  [2:0]        rdIdx = regIndex(rdAddr);

	// ****************************************
	// Storage, one slot per mapped offset
	// ****************************************
	for (genvar i = 0; i < REG_COUNT; i++) begin : gSlot
		// Writes to unmapped offsets fall through here unseen
		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b) regArr_r[i] <= RESET_VAL[i];
			else if (wrEn && wrIdx == 3'(i)) regArr_r[i] <= wrWord.data;
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	// Unmapped offsets read back as zero
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) rdData_r <= '0;
		else if (rdEn) rdData_r <= (rdIdx == IDX_NONE) ? '0 : regArr_r[rdIdx];
	end

	assign regs = '{regArr_r[0], regArr_r[1], regArr_r[2],
		regArr_r[3], regArr_r[4], regArr_r[5]};

endmodule : aimc_reg_bank

// ===== src/aimc_config_loader.sv
// Input mode configuration loader: serial register access, mode decode, conversion timing
module aimc_config_loader
	import aimc_pkg::*;
#(
	parameter int CYC_5SPS  = CONV_5SPS_CYC,
	parameter int CYC_10SPS = CONV_10SPS_CYC,
	parameter int CYC_20SPS = CONV_20SPS_CYC,
	parameter int CYC_40SPS = CONV_40SPS_CYC
) (
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic       sclk,
	input  wire logic       cs_b,
	input  wire logic       mosi,
	output logic            miso,
	input  wire logic       startIn,
	output logic            convDone_b,
	output aimc_analog_cfg_t acfg,
	output aimc_mode_t      cfgMode,
	output logic            rateWarn
);

	// ****************************************
	// Serial link domain (sclk)
	// ****************************************
	// Link-side state; the core reads only the toggles and the posted words
	logic [4:0]        bitCnt_r;
	logic [6:0]        shiftIn_r;
	logic [7:0]        cmd_r;
	logic              wrTog_r;
	logic              rdTog_r;
	aimc_spi_word_t    wrWord_r;
	logic [ADDR_W-1:0] rdAddr_r;
	logic [7:0]        misoShift_r;
	logic [1:0]        rdAckSync_r;
	logic              rdReady;

	// Frame ends clear the bit position without any sclk edge
	// The select pin doubles as a reset here; it is quiet whenever sclk moves
	wire spiRun_b = rst_b & ~cs_b;
	wire [7:0] rxByte  = {shiftIn_r, mosi};
	wire cmdDone  = (bitCnt_r == BIT_CMD_LAST);
	wire dataDone = (bitCnt_r == BIT_DATA_LAST);
	wire rxIsRead = rxByte[CMD_READ_BIT];
	wire cmdRead  = cmd_r[CMD_READ_BIT];

	// Bit position in the frame, saturating past the read byte
	// Saturation keeps long frames from wrapping back onto the command slot
	always_ff @(posedge sclk or negedge spiRun_b) begin
		if (!spiRun_b) bitCnt_r <= '0;
		else if (bitCnt_r != BIT_MAX) bitCnt_r <= bitCnt_r + 5'h01;
	end

	// Receive shifter, sampled on the rising edge
	// Only seven bits are kept; the live mosi bit completes each byte
	always_ff @(posedge sclk or negedge spiRun_b) begin
		if (!spiRun_b) shiftIn_r <= '0;
		else shiftIn_r <= rxByte[6:0];
	end

	// Command byte, kept for the rest of the frame
	// Cleared at frame end so a stray read flag never leaks into the next frame
	always_ff @(posedge sclk or negedge spiRun_b) begin
		if (!spiRun_b) cmd_r <= '0;
		else if (cmdDone) cmd_r <= rxByte;
	end

	// Read request; toggles survive frame ends so none is lost
	always_ff @(posedge sclk or negedge rst_b) begin
		if (!rst_b) begin
			rdTog_r  <= 1'b0;
			rdAddr_r <= '0;
		end else if (cs_b == 1'b0 && cmdDone && rxIsRead) begin
			rdTog_r  <= ~rdTog_r;
			rdAddr_r <= rxByte[ADDR_W-1:0];
		end
	end

	// Write request: word is held stable until the next write toggle
	// The core takes the word only after the toggle settles, so no bit is torn
	always_ff @(posedge sclk or negedge rst_b) begin
		if (!rst_b) begin
			wrTog_r  <= 1'b0;
			wrWord_r <= '0;
		end else if (cs_b == 1'b0 && dataDone && !cmdRead) begin
			wrTog_r  <= ~wrTog_r;
			wrWord_r <= '{cmd_r[ADDR_W-1:0], rxByte};
		end
	end

	// Transmit shifter, changed on the falling edge for the host to sample
	// Read data is loaded after a dummy byte, so the answer has long settled;
	// the echoed toggle must match too, else a late answer reads as zero
	// rather than as a half-changed byte
	logic [DATA_W-1:0] rdData;
	always_ff @(negedge sclk or negedge rst_b) begin
		if (!rst_b) misoShift_r <= '0;
		else if (bitCnt_r == BIT_READ_LOAD && cmdRead) misoShift_r <= rdReady ? rdData : '0;
		else misoShift_r <= {misoShift_r[6:0], 1'b0};
	end

	assign miso = misoShift_r[7];

	// ****************************************
	// Crossing into the core clock
	// ****************************************
	// Synchroniser and edge-detect state, all on the core clock
	logic [1:0] wrSync_r;
	logic [1:0] rdSync_r;
	logic [1:0] csSync_r;
	logic [1:0] startSync_r;
	logic       wrSeen_r;
	logic       rdSeen_r;
	logic       csPrev_r;

	// Two flops per crossing; the first is read by the second alone
	// Toggles rather than pulses cross, since sclk stops between frames
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wrSync_r    <= '0;
			rdSync_r    <= '0;
			csSync_r    <= 2'b11;
			startSync_r <= '0;
		end else begin
			wrSync_r    <= {wrSync_r[0], wrTog_r};
			rdSync_r    <= {rdSync_r[0], rdTog_r};
			csSync_r    <= {csSync_r[0], cs_b};
			startSync_r <= {startSync_r[0], startIn};
		end
	end

	// Last seen toggle and select levels for edge detection
	// Select resets high so the first frame after reset gives one clean edge
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wrSeen_r <= 1'b0;
			rdSeen_r <= 1'b0;
			csPrev_r <= 1'b1;
		end else begin
			wrSeen_r <= wrSync_r[1];
			rdSeen_r <= rdSync_r[1];
			csPrev_r <= csSync_r[1];
		end
	end

	wire wrPulse  = wrSync_r[1] ^ wrSeen_r;
	wire rdPulse  = rdSync_r[1] ^ rdSeen_r;
	wire csFall   = csPrev_r & ~csSync_r[1];
	wire startLvl = startSync_r[1];

	// Read echo back into the link domain; the core flips it with the data load.
	// Two sclk flops suffice: eight bit times pass before the answer is used.
	// Between frames sclk stands still, so the echo simply waits in place.
	always_ff @(posedge sclk or negedge rst_b) begin
		if (!rst_b) rdAckSync_r <= '0;
		else rdAckSync_r <= {rdAckSync_r[0], rdSeen_r};
	end

	assign rdReady = (rdAckSync_r[1] == rdTog_r);

	// ****************************************
	// Register bank
	// ****************************************
	// Bank runs on the core clock; the link only posts toggled requests to it
	aimc_regs_t regs;

	aimc_reg_bank uBank (
		.clock    (clock),
		.rst_b    (rst_b),
		.wrEn     (wrPulse),
		.wrWord   (wrWord_r),
		.rdEn     (rdPulse),
		.rdAddr   (rdAddr_r),
		.rdData_r (rdData),
		.regs     (regs)
	);

	// ****************************************
	// Field decode towards the analog front end
	// ****************************************
	// Industrial pairing is the one code off the plain pos/neg split
	// Other codes map their fields straight through, so a partial set still shows
	wire muxIsInd = (regs.inputMux == CODE_MUX_INDUSTRIAL);
	wire [2:0] posSel = muxIsInd ? 3'h0 : regs.inputMux[MUX_POS_LO+:3];
	wire [2:0] negSel = muxIsInd ? 3'h1 : regs.inputMux[MUX_NEG_LO+:3];

	aimc_analog_cfg_t cfgNxt;
	assign cfgNxt = '{
		muxPos:    posSel,
		muxNeg:    negSel,
		biasMask:  regs.bias,
		refSel:    regs.refMux[REF_SEL_LO+:2],
		gainCode:  regs.rateGain[GAIN_LO+:3],
		rateCode:  regs.rateGain[RATE_LO+:4],
		excMag:    regs.excMag[MAG_LO+:3],
		excRoute1: regs.excRoute[ROUTE1_LO+:4],
		excRoute2: regs.excRoute[ROUTE2_LO+:4]
	};

	// ****************************************
	// Mode recognition
	// ****************************************
	// Reports which documented set is fully loaded; partial sets show none
	// Mode is a report only; the fields above drive the front end regardless
	wire rgInd  = (regs.rateGain == CODE_RG_40SPS_G1) ||
	              (regs.rateGain == CODE_RG_40SPS_G2);
	wire rgTc   = (regs.rateGain == CODE_RG_5SPS_G32) ||
	              (regs.rateGain == CODE_RG_5SPS_G64);
	wire isInd  = muxIsInd && (regs.refMux == CODE_REF_PAIR0) && rgInd;
	wire isTc   = (regs.inputMux == CODE_MUX_THERMOCPL) &&
	              (regs.bias == CODE_BIAS_THERMOCPL) &&
	              (regs.refMux == CODE_REF_PAIR0) && rgTc;
	wire excOn  = (regs.excMag == CODE_EXC_1MA);
	wire isThm  = (regs.inputMux == CODE_MUX_THERMISTOR) &&
	              (regs.refMux == CODE_REF_PAIR1) &&
	              (regs.rateGain == CODE_RG_20SPS_G1) && excOn &&
	              (regs.excRoute == CODE_ROUTE_THERMIST);
	wire isRtd  = (regs.inputMux == CODE_MUX_RTD) &&
	              (regs.refMux == CODE_REF_PAIR1) &&
	              (regs.rateGain == CODE_RG_20SPS_G4) && excOn &&
	              (regs.excRoute == CODE_ROUTE_RTD);

	// Sets are disjoint, so the priority order never hides a match
	aimc_mode_t modeNxt;
	assign modeNxt = isInd ? MODE_INDUSTRIAL :
	                 isTc  ? MODE_THERMOCPL  :
	                 isThm ? MODE_THERMISTOR :
	                 isRtd ? MODE_RTD : MODE_NONE;

	// Thermocouple inputs faster than 20 per second pick up mains hum
	// Flag only: the host owns the rate choice, so nothing is refused here
	wire rateSlow = (cfgNxt.rateCode == RATE_CODE_5SPS) ||
	                (cfgNxt.rateCode == RATE_CODE_10SPS) ||
	                (cfgNxt.rateCode == RATE_CODE_20SPS);
	wire tcInputs = (regs.inputMux == CODE_MUX_THERMOCPL);
	wire warnNxt  = tcInputs && !rateSlow;

	// Registered so every front-end output comes from a flop
	// One cycle of latency is traded for glitch-free front-end selects
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			acfg     <= '0;
			cfgMode  <= MODE_NONE;
			rateWarn <= 1'b0;
		end else begin
			acfg     <= cfgNxt;
			cfgMode  <= modeNxt;
			rateWarn <= warnNxt;
		end
	end

	// ****************************************
	// Conversion timing
	// ****************************************
	// Rate codes above 20 per second all run at the 40 per second pace
	// Short test periods come in through the parameters, not the package
	wire [24:0] periodCyc =
		(cfgNxt.rateCode == RATE_CODE_5SPS)  ? 25'(CYC_5SPS)  :
		(cfgNxt.rateCode == RATE_CODE_10SPS) ? 25'(CYC_10SPS) :
		(cfgNxt.rateCode == RATE_CODE_20SPS) ? 25'(CYC_20SPS) :
		25'(CYC_40SPS);

	// Counter sized for the slowest rate at the default core clock
	aimc_conv_t convState_r;
	aimc_conv_t convState_nxt;
	logic [24:0] convCnt_r;
	logic [24:0] convCnt_nxt;
	logic        convEnd;

	// A register write restarts the period, so no result mixes two setups
	// Dropping start clears the count, so the next run begins a full period
	always_comb begin
		convState_nxt = convState_r;
		convCnt_nxt   = convCnt_r;
		convEnd       = 1'b0;
		case (convState_r)
			CONV_IDLE: begin
				convCnt_nxt = '0;
				if (startLvl) convState_nxt = CONV_RUN;
			end
			CONV_RUN: begin
				if (!startLvl) begin
					convState_nxt = CONV_IDLE;
					convCnt_nxt   = '0;
				end else if (wrPulse) begin
					convCnt_nxt = '0;
				end else if (convCnt_r >= periodCyc - 25'h1) begin
					convCnt_nxt = '0;
					convEnd     = 1'b1;
				end else begin
					convCnt_nxt = convCnt_r + 25'h1;
				end
			end
			default: begin
				convState_nxt = CONV_IDLE;
				convCnt_nxt   = '0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			convState_r <= CONV_IDLE;
			convCnt_r   <= '0;
		end else begin
			convState_r <= convState_nxt;
			convCnt_r   <= convCnt_nxt;
		end
	end

	// ****************************************
	// Conversion-done indication
	// ****************************************
	// Level, not pulse, so a slow host still sees every result
	// Low once a result is ready; a frame start or start going low releases it.
	// A completion in the releasing cycle wins, so no result is missed.
	wire doneClr = csFall || !startLvl;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) convDone_b <= 1'b1;
		else if (convEnd) convDone_b <= 1'b0;
		else if (doneClr) convDone_b <= 1'b1;
	end

endmodule : aimc_config_loader

// ===== verification/aimc_host_model.sv
// Host controller model: drives the serial link in mode 0 with an 80 ns bit clock
module aimc_host_model (
	output logic      sclk,
	output logic      cs_b,
	output logic      mosi,
	input  wire logic miso
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Link idle state and frame task
	// ****************************************
	// Bit clock stands low between frames
	initial begin
		sclk = 1'b0;
		cs_b = 1'b1;
		mosi = 1'b0;
	end

	// Shift n bits MSB first; rd keeps the last eight bits sampled on rising edges
	task automatic xfer(input logic [23:0] bits, input int n, output logic [7:0] rd);
		rd = 8'h00;
		#3 cs_b = 1'b0;
		#40;
		for (int i = 0; i < n; i++) begin
			mosi = bits[23-i];
			#40 sclk = 1'b1;
			rd = {rd[6:0], miso};
			#40 sclk = 1'b0;
		end
		#40 cs_b = 1'b1;
		mosi = ~mosi; // Released line shows no stale data
		#40;
	endtask : xfer
endmodule : aimc_host_model

// ===== verification/aimc_config_loader_chk.sv
// Checker: port-level assertions for the input mode loader
module aimc_config_loader_chk
	import aimc_pkg::*;
#(
	parameter int CYC_5SPS  = CONV_5SPS_CYC,
	parameter int CYC_10SPS = CONV_10SPS_CYC,
	parameter int CYC_20SPS = CONV_20SPS_CYC,
	parameter int CYC_40SPS = CONV_40SPS_CYC
) (
	input wire logic             clock,
	input wire logic             rst_b,
	input wire logic             sclk,
	input wire logic             cs_b,
	input wire logic             mosi,
	input wire logic             miso,
	input wire logic             startIn,
	input wire logic             convDone_b,
	input wire aimc_analog_cfg_t acfg,
	input wire aimc_mode_t       cfgMode,
	input wire logic             rateWarn
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	// ****************************************
	// Sequences
	// ****************************************
	// Link quiet long enough for any write to have landed
	sequence s_linkQuiet;
		cs_b[*8];
	endsequence
	sequence s_startLow;
		!startIn[*8];
	endsequence

	// ****************************************
	// Mode decode and link-only updates
	// ****************************************
	property p_industrial;
		cfgMode == MODE_INDUSTRIAL |-> acfg.muxPos == 3'h0 && acfg.muxNeg == 3'h1
			&& acfg.refSel == 2'h0 && acfg.rateCode == 4'h3 && acfg.gainCode <= 3'h1;
	endproperty
	a_industrial: assert property (p_industrial)
		else $error("industrial decode wrong");
	property p_thermocpl;
		cfgMode == MODE_THERMOCPL |-> acfg.muxPos == 3'h3 && acfg.muxNeg == 3'h2
			&& acfg.biasMask == 8'h04 && acfg.refSel == 2'h0 && acfg.rateCode == 4'h0
			&& (acfg.gainCode == 3'h5 || acfg.gainCode == 3'h6) && !rateWarn;
	endproperty
	a_thermocpl: assert property (p_thermocpl)
		else $error("thermocouple decode wrong");
	property p_thermistor;
		cfgMode == MODE_THERMISTOR |-> acfg.muxPos == 3'h7 && acfg.muxNeg == 3'h6
			&& acfg.refSel == 2'h1 && acfg.gainCode == 3'h0 && acfg.rateCode == 4'h2
			&& acfg.excMag == 3'h6 && acfg.excRoute1 == 4'h7 && acfg.excRoute2 == 4'h6;
	endproperty
	a_thermistor: assert property (p_thermistor)
		else $error("thermistor decode wrong");
	property p_rtd;
		cfgMode == MODE_RTD |-> acfg.muxPos == 3'h4 && acfg.muxNeg == 3'h5
			&& acfg.refSel == 2'h1 && acfg.gainCode == 3'h2 && acfg.rateCode == 4'h2
			&& acfg.excMag == 3'h6 && acfg.excRoute1 == 4'h8 && acfg.excRoute2 == 4'h9;
	endproperty
	a_rtd: assert property (p_rtd)
		else $error("rtd decode wrong");
	property p_rateWarn;
		rateWarn |-> acfg.muxPos == 3'h3 && acfg.muxNeg == 3'h2 && acfg.rateCode > 4'h2;
	endproperty
	a_rateWarn: assert property (p_rateWarn) else $error("rate flag wrong");
	property p_acfgQuiet;
		s_linkQuiet |=> $stable(acfg);
	endproperty
	a_acfgQuiet: assert property (p_acfgQuiet) else $error("config moved, link idle");
	property p_modeQuiet;
		s_linkQuiet |=> $stable(cfgMode) && $stable(rateWarn);
	endproperty
	a_modeQuiet: assert property (p_modeQuiet) else $error("mode moved, link idle");
	// Done must drop back once start has been low past the synchroniser
	property p_doneRelease;
		s_startLow |=> convDone_b;
	endproperty
	a_doneRelease: assert property (p_doneRelease) else $error("done held, start low");
	// A result may only appear while start has been seen high
	property p_doneNeedsStart;
		$fell(convDone_b) |-> $past(startIn, 3);
	endproperty
	a_doneNeedsStart: assert property (p_doneNeedsStart) else $error("done without start");
endmodule : aimc_config_loader_chk

bind aimc_config_loader aimc_config_loader_chk #(.CYC_5SPS(CYC_5SPS), .CYC_10SPS(CYC_10SPS),
	.CYC_20SPS(CYC_20SPS), .CYC_40SPS(CYC_40SPS)) chk (.clock(clock), .rst_b(rst_b),
	.sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso), .startIn(startIn),
	.convDone_b(convDone_b), .acfg(acfg), .cfgMode(cfgMode), .rateWarn(rateWarn));

// ===== verification/testbench.sv
// Testbench: register access, mode loading and conversion timing of the input mode loader
module testbench
	import aimc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Settings, tables and signals
	// ****************************************
	// Short periods keep the run small; expectations use the same values
	localparam int PER [4] = '{400, 200, 100, 50};
	localparam logic [7:0] RGS [4] = '{8'h50, 8'h01, 8'h02, 8'h13};
	localparam logic [3:0] OFS [6] = '{OFS_INPUT_MUX, OFS_BIAS, OFS_REF_MUX,
		OFS_RATE_GAIN, OFS_EXC_MAG, OFS_EXC_ROUTE};
	localparam logic [47:0] SETS [6] = '{48'h0800_0003_00FF, 48'h0800_0013_00FF,
		48'h1A04_0050_00FF, 48'h1A04_0060_00FF, 48'h3E00_2802_0676, 48'h2500_2822_0689};
	localparam aimc_mode_t MODES [6] = '{MODE_INDUSTRIAL, MODE_INDUSTRIAL, MODE_THERMOCPL,
		MODE_THERMOCPL, MODE_THERMISTOR, MODE_RTD};
	localparam logic [5:0] PN [6] = '{6'h01, 6'h01, 6'h1A, 6'h1A, 6'h3E, 6'h25};
	logic             clock;
	logic             rst_b;
	logic             sclk;
	logic             cs_b;
	logic             mosi;
	logic             miso;
	logic             startIn;
	logic             convDone_b;
	aimc_analog_cfg_t acfg;
	aimc_mode_t       cfgMode;
	logic             rateWarn;
	int               errors = 0;
	int               compares = 0;
	int               cycles = 0;

	aimc_config_loader #(.CYC_5SPS(PER[0]), .CYC_10SPS(PER[1]), .CYC_20SPS(PER[2]),
		.CYC_40SPS(PER[3])) uut (.clock(clock), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
		.mosi(mosi), .miso(miso), .startIn(startIn), .convDone_b(convDone_b), .acfg(acfg),
		.cfgMode(cfgMode), .rateWarn(rateWarn));
	aimc_host_model host (.sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso));

	// ****************************************
	// Clock, timeout and tasks
	// ****************************************
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// Ceiling well above the roughly 21k cycles the tests need
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			errors++;
			conclude();
		end
	end
	task automatic conclude();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude
	// Callers pass values read off the clock edge; the wait spaces the compares
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		@(negedge clock);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] q;
		host.xfer({4'h0, a, d, 8'h00}, 16, q);
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		host.xfer({4'h8, a, 16'h0000}, 24, d);
	endtask : rd
	task automatic waitDone(output int n);
		n = 0;
		while (convDone_b !== 1'b0 && n < 1000) begin
			@(negedge clock);
			n++;
		end
	endtask : waitDone

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		logic [7:0]  q;
		logic [47:0] s;
		int          n;
		rst_b = 1'b0;
		startIn = 1'b0;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		repeat (4) @(posedge clock);
		check(acfg, {6'h01, 8'h00, 2'h0, 7'h00, 3'h0, 8'hFF});
		check(cfgMode, MODE_NONE);
		for (int k = 0; k < 6; k++) begin
			rd(OFS[k], q);
			check(q, RESET_VAL[k]);
		end
		$display("test reset values finished");
		for (int i = 0; i < 6; i++) begin
			s = SETS[i];
			for (int k = 0; k < 6; k++) wr(OFS[k], s[47-8*k -: 8]);
			check(acfg, {PN[i], s[39:32], s[28:27], s[22:16], s[10:8], s[7:0]});
			check(cfgMode, MODES[i]);
			for (int k = 0; k < 6; k++) begin
				rd(OFS[k], q);
				check(q, s[47-8*k -: 8]);
			end
		end
		$display("test mode sets finished");
		host.xfer({4'h0, OFS_RATE_GAIN, 8'h55, 8'h00}, 12, q);
		rd(OFS_RATE_GAIN, q);
		check(q, 8'h22);
		wr(4'h5, 8'hAA);
		rd(4'h5, q);
		check(q, 8'h00);
		$display("test abort and unmapped finished");
		wr(OFS_INPUT_MUX, 8'h1A);
		wr(OFS_RATE_GAIN, 8'h03);
		check(rateWarn, 1'b1);
		wr(OFS_RATE_GAIN, 8'h02);
		check(rateWarn, 1'b0);
		$display("test rate flag finished");
		for (int i = 0; i < 4; i++) begin
			wr(OFS_RATE_GAIN, RGS[i]);
			@(posedge clock);
			startIn <= 1'b1;
			waitDone(n);
			check(n >= PER[i] + 1 && n <= PER[i] + 7, 1'b1);
			host.xfer(24'h000000, 1, q);
			check(convDone_b, 1'b1);
			waitDone(n);
			check(n <= PER[i], 1'b1);
			@(posedge clock);
			startIn <= 1'b0;
			repeat (8) @(posedge clock);
			check(convDone_b, 1'b1);
		end
		$display("test conversion timing finished");
		conclude();
	end
endmodule : testbench
